//--- rtl/ptc_timer.v
/*
 16-bit prescaled timer/counter with overflow and external-pin interrupts.
 assumes: one clock clk (the instruction clock), asynchronous active-low reset,
 register port with read data one cycle after the read strobe, pins asynchronous
 and passed through synchronisers.
*/
`timescale 1ns/100ps
`include "ptc_defs.vh"

// How it works
// - the counter is 16 bits wide and software sees it as a low and a high byte register.
// - an 8-bit prescaler sits ahead of the counter, stretching overflow to a 24-bit period.
// - control bit 5 set counts the internal clock, clear counts the external count pin.
// - with the pin selected, control bit 6 set counts rising edges and clear counts falling edges.
// - the prescale field in bits 4 to 1 gives 1:8 at 0011, 16 to 128 at 0100 to 0111, 256 with bit 4 set.
// - the counter runs 0000h to FFFFh and wraps to 0000h without stopping.
// - the wrap from FFFFh to 0000h sets the overflow flag.
// - the overflow flag raises the interrupt only while its enable bit is set.
// - entry to the overflow vector clears the overflow flag in hardware.
// - control bit 7 picks which edge of the external interrupt pin raises an event.
// - the control register sits at 05h, resets to zero, and its bit 0 reads as zero.
// - the external path is synchronised ahead of the prescaler and sampled for edges before counting.
module ptc_timer (
   // clock and reset
   input  wire       clk,
   input  wire       arst_n,
   // register port
   input  wire [7:0] addr,
   input  wire [7:0] wdata,
   input  wire       wr_en,
   input  wire       rd_en,
   output reg  [7:0] rdata,
   // pins
   input  wire       external_count_pin,
   input  wire       external_irq_pin,
   // vector entry from the core
   input  wire       overflow_vector_ack,
   // interrupt
   output reg        irq
);

   reg  [7:0]  counter_control;
   reg  [15:0] count_value;
   reg  [7:0]  irq_status;
   reg  [7:0]  irq_mask;
   reg  [7:0]  next_rdata;
   reg  [7:0]  next_status;
   reg  [15:0] next_count;

   wire        count_source_select = counter_control[`PTC_CTL_SRC_SEL];
   wire        count_edge_select   = counter_control[`PTC_CTL_CNT_EDGE];
   wire        ext_irq_edge_select = counter_control[`PTC_CTL_EXT_EDGE];
   wire [3:0]  prescale_select     = counter_control[`PTC_CTL_PS_HI:`PTC_CTL_PS_LO];
   wire        overflow_irq_enable = irq_mask[`PTC_IRQ_OVF];

   wire        wr_ctl   = wr_en && (addr == `PTC_ADDR_CONTROL);
   wire        wr_lo    = wr_en && (addr == `PTC_ADDR_COUNT_LO);
   wire        wr_hi    = wr_en && (addr == `PTC_ADDR_COUNT_HI);
   wire        wr_stat  = wr_en && (addr == `PTC_ADDR_IRQ_STAT);
   wire        wr_mask  = wr_en && (addr == `PTC_ADDR_IRQ_MASK);
   wire        wr_vec   = wr_en && (addr == `PTC_ADDR_VECTOR);

   wire        cnt_pin_edge;
   wire        ext_irq_edge;
   wire        int_tick;
   wire        ext_tick;
   wire        prescaler_output;
   wire        cnt_tick;
   wire        wrap;
   wire        vec_ack;

   // external count edge, selected edge, detected after synchronisation
   ptc_edge_sync u_cnt_sync (
      .clk        (clk),
      .arst_n     (arst_n),
      .din        (external_count_pin),
      .rise_sel   (count_edge_select),
      .edge_pulse (cnt_pin_edge)
   );

   // external interrupt pin edge, own edge select bit
   ptc_edge_sync u_irq_sync (
      .clk        (clk),
      .arst_n     (arst_n),
      .din        (external_irq_pin),
      .rise_sel   (ext_irq_edge_select),
      .edge_pulse (ext_irq_edge)
   );

   // internal source ticks every instruction clock; pin source ticks per selected edge
   assign int_tick = count_source_select;
   assign ext_tick = ~count_source_select & cnt_pin_edge;

   // one shared 8-bit prescaler ahead of the counter; a control write restarts it
   ptc_prescaler #(
      .WIDTH (8)
   ) u_presc (
      .clk        (clk),
      .arst_n     (arst_n),
      .ratio_code (prescale_select),
      .clear      (wr_ctl),
      .tick_in    (int_tick | ext_tick),
      .tick_out   (prescaler_output)
   );

   // with ratio 1:1 the prescaler still adds a cycle of latency; keeps timing uniform
   assign cnt_tick = prescaler_output;
   assign wrap     = cnt_tick && (count_value == 16'hFFFF);
   assign vec_ack  = overflow_vector_ack | (wr_vec & wdata[`PTC_VEC_OVF_ACK]);

   // counter next value: byte loads win over counting in the same cycle
   always @* begin
      next_count = count_value;
      if (cnt_tick)
         next_count = count_value + 16'h0001;
      if (wr_lo)
         next_count[7:0] = wdata;
      if (wr_hi)
         next_count[15:8] = wdata;
   end

   // counter register
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         count_value <= 16'h0000;
      else
         count_value <= next_count;
   end

   // control register; bit 0 is not stored
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         counter_control <= `PTC_CTL_RESET;
      else if (wr_ctl)
         counter_control <= wdata & `PTC_CTL_WMASK;
   end

   // sticky status: set wins over a write-one clear or a vector entry in the same cycle
   always @* begin
      next_status = irq_status;
      if (wr_stat)
         next_status = next_status & ~(wdata & `PTC_IRQ_BITS);
      if (vec_ack)
         next_status[`PTC_IRQ_OVF] = 1'b0;
      if (wrap)
         next_status[`PTC_IRQ_OVF] = 1'b1;
      if (ext_irq_edge)
         next_status[`PTC_IRQ_EXT] = 1'b1;
   end

   // status, mask and the level interrupt output
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_status <= `PTC_IRQ_RESET;
         irq_mask   <= `PTC_IRQ_RESET;
         irq        <= 1'b0;
      end else begin
         irq_status <= next_status;
         if (wr_mask)
            irq_mask <= wdata & `PTC_IRQ_BITS;
         irq        <= |(next_status & (wr_mask ? (wdata & `PTC_IRQ_BITS) : irq_mask));
      end
   end

   // read mux; unmapped addresses read zero
   always @* begin
      case (addr)
         `PTC_ADDR_CONTROL:  next_rdata = counter_control;
         `PTC_ADDR_COUNT_LO: next_rdata = count_value[7:0];
         `PTC_ADDR_COUNT_HI: next_rdata = count_value[15:8];
         `PTC_ADDR_IRQ_STAT: next_rdata = irq_status;
         `PTC_ADDR_IRQ_MASK: next_rdata = irq_mask;
         default:            next_rdata = 8'h00;
      endcase
   end

   // read data stands the cycle after the strobe only
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         rdata <= 8'h00;
      else if (rd_en)
         rdata <= next_rdata;
      else
         rdata <= 8'h00;
   end

endmodule // ptc_timer

//--- rtl/ptc_defs.vh
/*
 prescaled timer counter: register offsets, field positions and reset values.
 assumes: included by the timer design files only, by its bare name.
*/
`ifndef PTC_DEFS_VH
`define PTC_DEFS_VH

// register offsets (byte addresses on the 8-bit register port)
`define PTC_ADDR_CONTROL   8'h05
`define PTC_ADDR_COUNT_LO  8'h10
`define PTC_ADDR_COUNT_HI  8'h11
`define PTC_ADDR_IRQ_STAT  8'h12
`define PTC_ADDR_IRQ_MASK  8'h13
`define PTC_ADDR_VECTOR    8'h14

// control register fields
`define PTC_CTL_EXT_EDGE   7
`define PTC_CTL_CNT_EDGE   6
`define PTC_CTL_SRC_SEL    5
`define PTC_CTL_PS_HI      4
`define PTC_CTL_PS_LO      1
`define PTC_CTL_WMASK      8'hFE
`define PTC_CTL_RESET      8'h00

// interrupt status / mask bits
`define PTC_IRQ_OVF        0
`define PTC_IRQ_EXT        1
`define PTC_IRQ_BITS       8'h03
`define PTC_IRQ_RESET      8'h00

// vector acknowledge register bit: writing one marks entry to the overflow vector
`define PTC_VEC_OVF_ACK    0

`endif

//--- rtl/ptc_edge_sync.v
/*
 two flip-flop synchroniser with a rising/falling edge detector on the output.
 assumes: single clock domain clk, asynchronous active-low reset.
*/
`timescale 1ns/100ps

module ptc_edge_sync (
   // clock and reset
   input  wire clk,
   input  wire arst_n,
   // signal in
   input  wire din,
   input  wire rise_sel,
   // detected edge
   output reg  edge_pulse
);

   reg meta;
   reg sync;
   reg last;

   // first stage feeds only the second stage; edge logic looks at stage two
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta       <= 1'b0;
         sync       <= 1'b0;
         last       <= 1'b0;
         edge_pulse <= 1'b0;
      end else begin
         meta       <= din;
         sync       <= meta;
         last       <= sync;
         edge_pulse <= rise_sel ? (sync & ~last) : (~sync & last);
      end
   end

endmodule // ptc_edge_sync

//--- rtl/ptc_prescaler.v
/*
 programmable power-of-two prescaler, 1:1 to 1:256.
 assumes: tick_in is a one-cycle pulse per source event, in the clk domain.
*/
`timescale 1ns/100ps

module ptc_prescaler #(
   parameter WIDTH = 8
) (
   // clock and reset
   input  wire       clk,
   input  wire       arst_n,
   // control
   input  wire [3:0] ratio_code,
   input  wire       clear,
   // events
   input  wire       tick_in,
   output reg        tick_out
);

   reg [WIDTH-1:0] div_cnt;

   // terminal count for a code: 2**code - 1, capped at code 8
   function [WIDTH-1:0] term_of;
      input [3:0] code;
      begin
         if (code[3])
            term_of = {WIDTH{1'b1}};
         else
            term_of = ({{(WIDTH-1){1'b0}}, 1'b1} << code[2:0]) - {{(WIDTH-1){1'b0}}, 1'b1};
      end
   endfunction

   // divide the source ticks; a clear restarts the division cleanly
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         div_cnt  <= {WIDTH{1'b0}};
         tick_out <= 1'b0;
      end else if (clear) begin
         div_cnt  <= {WIDTH{1'b0}};
         tick_out <= 1'b0;
      end else if (tick_in) begin
         if (div_cnt >= term_of(ratio_code)) begin
            div_cnt  <= {WIDTH{1'b0}};
            tick_out <= 1'b1;
         end else begin
            div_cnt  <= div_cnt + {{(WIDTH-1){1'b0}}, 1'b1};
            tick_out <= 1'b0;
         end
      end else begin
         tick_out <= 1'b0;
      end
   end

endmodule // ptc_prescaler

//--- testbench/ptc_timer_asserts.sv
/*
 checker for the ptc_timer register port and interrupt output.
 assumes: bound to ptc_timer, one clock clk, reset arst_n.
*/
`timescale 1ns/100ps

module ptc_timer_asserts (
   // clock and reset
   input logic       clk,
   input logic       arst_n,
   // register port
   input logic [7:0] addr,
   input logic [7:0] wdata,
   input logic       wr_en,
   input logic       rd_en,
   input logic [7:0] rdata,
   // vector entry and interrupt
   input logic       overflow_vector_ack,
   input logic       irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);

   // write to a place, then read it straight back
   sequence s_wr_rd(a);
      wr_en && addr == a ##1 rd_en && addr == a;
   endsequence
   // clear the overflow flag, then read the status
   sequence s_clr_rd;
      (overflow_vector_ack || wr_en && addr == 8'h12 && wdata[0]) ##1 rd_en && addr == 8'h12;
   endsequence

   property p_rd_idle;
      !rd_en |=> rdata == 8'h00;
   endproperty
   property p_ctl_b0;
      rd_en && addr == 8'h05 |=> !rdata[0];
   endproperty
   property p_unmapped;
      rd_en && (addr >= 8'h14 || addr < 8'h05) |=> rdata == 8'h00;
   endproperty
   property p_ctl_rw;
      s_wr_rd(8'h05) |=> rdata == ($past(wdata, 2) & 8'hFE);
   endproperty
   // the read samples the loaded byte before any tick lands; the check also accepts one more
   property p_lo_load;
      s_wr_rd(8'h10) |=> rdata == $past(wdata, 2) || rdata == $past(wdata, 2) + 8'h01;
   endproperty
   property p_hi_load;
      s_wr_rd(8'h11) |=> rdata == $past(wdata, 2) || rdata == $past(wdata, 2) + 8'h01;
   endproperty
   property p_mask_off;
      wr_en && addr == 8'h13 && wdata[1:0] == 2'b00 |-> ##2 !irq;
   endproperty
   property p_ovf_clr;
      s_clr_rd |=> !rdata[0];
   endproperty

   a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside a read");
   a_ctl_b0: assert property (p_ctl_b0) else $error("control bit 0 read as one");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_ctl_rw: assert property (p_ctl_rw) else $error("control readback wrong");
   a_lo_load: assert property (p_lo_load) else $error("low byte load wrong");
   a_hi_load: assert property (p_hi_load) else $error("high byte load wrong");
   a_mask_off: assert property (p_mask_off) else $error("irq high with mask clear");
   a_ovf_clr: assert property (p_ovf_clr) else $error("overflow flag not cleared");
endmodule // ptc_timer_asserts

bind ptc_timer ptc_timer_asserts ptc_timer_asserts_i (.clk(clk), .arst_n(arst_n), .addr(addr),
   .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
   .overflow_vector_ack(overflow_vector_ack), .irq(irq));

//--- testbench/ptc_pin_src.sv
/*
 behavioural source for the count pin and the external interrupt pin.
 assumes: the timer synchronises both pins, so edges need no clock alignment.
*/
`timescale 1ns/100ps

module ptc_pin_src (
   // pins toward the timer
   output logic count_pin,
   output logic irq_pin
);
   // both pins rest low between scenarios
   initial begin
      count_pin = 1'b0;
      irq_pin = 1'b0;
   end
   // n pulses, each phase t ns; keep t above one clock or the synchroniser can drop them
   task pulses(int n, int t);
      #1;
      repeat (n) begin
         #t count_pin = 1'b1;
         #t count_pin = 1'b0;
      end
   endtask
   // move the interrupt pin off any clock edge
   task ext_irq(logic v);
      #13 irq_pin = v;
   endtask
endmodule // ptc_pin_src

//--- testbench/tb.sv
/*
 self-checking bench for ptc_timer.
 assumes: ptc_pin_src drives both pins; 125 MHz clock.
*/
`timescale 1ns/100ps

module tb;
   logic       clk, arst_n, wr_en, rd_en, ack, irq;
   logic [7:0] addr, wdata, rdata;
   logic [3:0] code;
   wire        cnt_pin, irq_pin;
   int         failures, tests_run, cycles, r;
   logic [7:0] regs [7] = '{8'h05, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h20};

   ptc_timer ptc_timer_i (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
      .rd_en(rd_en), .rdata(rdata), .external_count_pin(cnt_pin), .external_irq_pin(irq_pin),
      .overflow_vector_ack(ack), .irq(irq));
   ptc_pin_src ptc_pin_src_i (.count_pin(cnt_pin), .irq_pin(irq_pin));

   task chk(logic [7:0] got, logic [7:0] exp, string what);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // tasks start and end just after a rising edge
   task wr(logic [7:0] a, logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   task rd(logic [7:0] a, logic [7:0] e);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 chk(rdata, e, "read");
      @(posedge clk);
   endtask
   task idle(int n);
      repeat (n) @(posedge clk);
   endtask
   task irq_is(logic e);
      #1 chk({7'h00, irq}, {7'h00, e}, "irq");
      @(posedge clk);
   endtask
   task tally_and_finish;
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // hang guard, well above the longest prescale sweep
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 12000) begin
         failures++;
         $display("[FAIL] %0t timeout", $time);
         tally_and_finish();
      end
   end

   initial begin
      {arst_n, wr_en, rd_en, ack, addr, wdata} = '0;
      idle(4);
      arst_n <= 1'b1;
      foreach (regs[i]) rd(regs[i], 8'h00);
      wr(8'h05, 8'hFF);
      rd(8'h05, 8'hFE);
      $display("test registers done");
      // external rising edges, divide by one, count holds for the readback, then three pulses add three
      wr(8'h05, 8'h40);
      wr(8'h11, 8'h12);
      wr(8'h10, 8'h34);
      rd(8'h10, 8'h34);
      rd(8'h11, 8'h12);
      ptc_pin_src_i.pulses(3, 40);
      idle(8);
      rd(8'h10, 8'h37);
      // falling edges, divide by two; rewrite restarts a prescaler a spurious edge may have moved
      wr(8'h05, 8'h02);
      idle(6);
      wr(8'h05, 8'h02);
      wr(8'h10, 8'h00);
      ptc_pin_src_i.pulses(4, 24);
      idle(8);
      rd(8'h10, 8'h02);
      $display("test external done");
      for (int c = 0; c < 10; c++) begin
         code = (c == 9) ? 4'hF : c[3:0];
         r = code[3] ? 256 : (1 << code);
         wr(8'h05, 8'h00);
         wr(8'h10, 8'h00);
         wr(8'h05, {3'b001, code, 1'b0});
         idle(3 * r + 1);
         rd(8'h10, 8'h03);
      end
      $display("test prescale done");
      wr(8'h05, 8'h00);
      wr(8'h13, 8'h01);
      wr(8'h10, 8'hFE);
      wr(8'h11, 8'hFF);
      irq_is(1'b0);
      ptc_pin_src_i.pulses(2, 40);
      idle(8);
      rd(8'h11, 8'h00);
      rd(8'h12, 8'h01);
      irq_is(1'b1);
      wr(8'h13, 8'h00);
      idle(2);
      irq_is(1'b0);
      wr(8'h13, 8'h01);
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      rd(8'h12, 8'h00);
      irq_is(1'b0);
      wr(8'h11, 8'hFF);
      wr(8'h10, 8'hFF);
      ptc_pin_src_i.pulses(1, 40);
      idle(8);
      rd(8'h12, 8'h01);
      wr(8'h12, 8'h01);
      rd(8'h12, 8'h00);
      $display("test overflow done");
      // falling edge selected: a rise must not set the pin flag
      wr(8'h12, 8'h03);
      ptc_pin_src_i.ext_irq(1'b1);
      idle(6);
      rd(8'h12, 8'h00);
      ptc_pin_src_i.ext_irq(1'b0);
      idle(6);
      rd(8'h12, 8'h02);
      wr(8'h05, 8'h80);
      idle(6);
      wr(8'h12, 8'h03);
      ptc_pin_src_i.ext_irq(1'b1);
      idle(6);
      rd(8'h12, 8'h02);
      $display("test pin edge done");
      tally_and_finish();
   end
endmodule // tb
